// file: hdl/mie_exec.sv
// Four-phase executor for move, load and increment-skip instructions
//
// Overview of operation
// - Move file goes to working or file
// - File-to-file move refuses program counter low byte, stack tops
// - File-to-file move: read cycle, then write cycle
// - Bank literal load, one cycle, flags untouched
// - Pointer load: high nibble, then low byte
// - Increment skip zero discards next instruction words
// - Store uses access bank or bank selector
`timescale 1ns/1ps
`include "mie_consts.svh"

module mie_exec
    import mie_pkg::*;
#(
    parameter int NUM_PTR = `MIE_PTR_COUNT  // Indirect pointer count
)
(
    input  wire logic                       clk_i,         // 125 MHz
    input  wire logic                       rst_n_i,       // Async, low
    input  wire logic [15:0]                instr_i,       // Fetched word
    input  wire logic                       instr_valid_i, // Word present
    output logic                            word_take_o,   // Word taken
    output logic      [1:0]                 phase_o,       // Current phase
    output logic      [11:0]                mem_addr_o,    // Data address
    input  wire logic [7:0]                 mem_rdata_i,   // Read data
    output logic      [7:0]                 mem_wdata_o,   // Write data
    output logic                            mem_we_o,      // Write strobe
    output logic      [7:0]                 working_o,     // Working reg
    output logic      [7:0]                 bank_select_reg_o, // Bank sel
    output logic      [NUM_PTR-1:0][11:0]   pointer_o,     // Pointers
    output logic                            zero_flag_o,   // Z flag
    output logic                            neg_flag_o,    // N flag
    output logic                            bad_dest_o     // Refused move
);

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    // The state struct is sized from the shared pointer count
    if (NUM_PTR != `MIE_PTR_COUNT || NUM_PTR > 4)
    begin : g_bad_ptr
        $error("NUM_PTR must equal the shared pointer count");
    end

    // ****************************************************************
    // State and helpers
    // ****************************************************************
    mie_state_s     q;          // Registered state
    mie_state_s     d;          // Next state
    logic [15:0]    instr_w;    // Word seen at decode
    logic [11:0]    bank_addr;  // Resolved banked address
    logic [7:0]     inc_val;    // Incremented read data
    logic           two_word;   // Word opens a two-word instruction
    logic           dest_bad;   // Protected destination

    // Missing words decode as idle cycles
    assign instr_w = instr_valid_i ? instr_i : `MIE_NOP_WORD;
    assign inc_val = q.data + `MIE_ONE_BYTE;

    // Two-word openers; their second word must also be discarded
    assign two_word = (instr_w[15:12] == `MIE_FF_MOVE_CODE)
                   || (instr_w[15:6]  == `MIE_PTR_LOAD_CODE)
                   || (instr_w[15:9]  == `MIE_CALL_CODE)
                   || (instr_w[15:8]  == `MIE_GOTO_CODE);

    // Program counter low and stack top bytes are never file-to-file move targets
    assign dest_bad = (q.addr == `MIE_PC_LOW_ADDR)
                   || (q.addr == `MIE_TOS_UPPER_ADDR)
                   || (q.addr == `MIE_TOS_HIGH_ADDR)
                   || (q.addr == `MIE_TOS_LOW_ADDR);

    // Banked addressing for one-word file instructions
    mie_bank_addr i_mie_bank_addr
    (
        .file_i   (instr_w[7:0]),
        .bank_a_i (instr_w[8]),
        .bank_i   (q.bank[3:0]),
        .addr_o   (bank_addr)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // One phase per clock; four clocks make one instruction cycle
    always_comb
    begin
        d          = q;
        d.phase    = q.phase + 2'd1;
        d.we       = 1'b0;
        d.bad_dest = 1'b0;
        unique case (q.phase)
            `MIE_Q1_DECODE:
            begin
                if (q.st == ST_FF2)
                begin
                    // Second word: destination, no dummy read
                    d.op   = OP_FF2;
                    d.addr = instr_w[11:0];
                    d.st   = ST_NORM;
                end
                else if (q.st == ST_LF2)
                begin
                    d.op  = OP_LF2;
                    d.lit = instr_w[7:0];
                    d.st  = ST_NORM;
                end
                else if (q.skip)
                begin
                    // Discarded fetch runs as an idle cycle
                    d.op   = OP_NOP;
                    d.skip = two_word;
                end
                else
                begin
                    d.op   = OP_NOP;
                    d.dbit = instr_w[9];
                    d.lit  = instr_w[7:0];
                    d.khi  = instr_w[3:0];
                    d.sel  = instr_w[5:4];
                    d.addr = bank_addr;
                    if (instr_w[15:10] == `MIE_MOVE_FILE_CODE)
                        d.op = OP_MOVE_FILE;
                    else if (instr_w[15:10] == `MIE_INC_SKIP_CODE)
                        d.op = OP_INC_SKIP;
                    else if (instr_w[15:9] == `MIE_STORE_W_CODE)
                        d.op = OP_STORE_W;
                    else if (instr_w[15:8] == `MIE_BANK_LIT_CODE)
                        d.op = OP_BANK_LIT;
                    else if (instr_w[15:12] == `MIE_FF_MOVE_CODE)
                    begin
                        // Source reaches the whole 4096-byte space
                        d.op   = OP_FF1;
                        d.addr = instr_w[11:0];
                        d.st   = ST_FF2;
                    end
                    else if (instr_w[15:6] == `MIE_PTR_LOAD_CODE)
                    begin
                        d.op = OP_LF1;
                        d.st = ST_LF2;
                    end
                end
            end
            `MIE_Q2_READ:
            begin
                // Only file reads sample memory; second words do not
                if (q.op == OP_MOVE_FILE || q.op == OP_INC_SKIP
                    || q.op == OP_FF1)
                    d.data = mem_rdata_i;
            end
            `MIE_Q3_PROCESS:
            begin
                // Strobe stands through the write phase
                if (q.op == OP_STORE_W)
                begin
                    d.we    = 1'b1;
                    d.wdata = q.w;
                end
                else if (q.op == OP_MOVE_FILE && q.dbit)
                begin
                    d.we    = 1'b1;
                    d.wdata = q.data;
                end
                else if (q.op == OP_INC_SKIP && q.dbit)
                begin
                    d.we    = 1'b1;
                    d.wdata = inc_val;
                end
                else if (q.op == OP_FF2)
                begin
                    d.we       = !dest_bad;
                    d.bad_dest = dest_bad;
                    d.wdata    = q.data;
                end
                if (q.op == OP_INC_SKIP)
                    d.data = inc_val;
            end
            `MIE_Q4_WRITE:
            begin
                if (q.op == OP_MOVE_FILE)
                begin
                    if (!q.dbit)
                        d.w = q.data;
                    d.zf = (q.data == `MIE_ZERO_BYTE);
                    d.nf = q.data[7];
                end
                else if (q.op == OP_INC_SKIP)
                begin
                    // Flags untouched; a zero result skips the next word
                    if (!q.dbit)
                        d.w = q.data;
                    d.skip = (q.data == `MIE_ZERO_BYTE);
                end
                else if (q.op == OP_BANK_LIT)
                begin
                    d.bank = q.lit;
                end
                else if (q.op == OP_LF1 && int'(q.sel) < NUM_PTR)
                begin
                    d.ptr_hi[q.sel] = q.khi;
                end
                else if (q.op == OP_LF2 && int'(q.sel) < NUM_PTR)
                begin
                    d.ptr_lo[q.sel] = q.lit;
                end
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Handshake is combinational; everything else is registered
    assign word_take_o       = (q.phase == `MIE_Q1_DECODE);
    assign phase_o           = q.phase;
    assign mem_addr_o        = q.addr;
    assign mem_wdata_o       = q.wdata;
    assign mem_we_o          = q.we;
    assign working_o         = q.w;
    assign bank_select_reg_o = q.bank;
    assign zero_flag_o       = q.zf;
    assign neg_flag_o        = q.nf;
    assign bad_dest_o        = q.bad_dest;

    // Pointer high nibble over low byte, per entry
    for (genvar i = 0; i < NUM_PTR; i++)
    begin : g_ptr
        assign pointer_o[i] = {q.ptr_hi[i], q.ptr_lo[i]};
    end

endmodule // mie_exec

// file: include/mie_consts.svh
// Named constants for the move and increment execution block
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH

// ****************************************************************
// Phase encodings within one instruction cycle
// ****************************************************************
`define MIE_Q1_DECODE       2'd0
`define MIE_Q2_READ         2'd1
`define MIE_Q3_PROCESS      2'd2
`define MIE_Q4_WRITE        2'd3

// ****************************************************************
// Opcode match fields
// ****************************************************************
`define MIE_NOP_WORD        16'h0000
`define MIE_MOVE_FILE_CODE  6'h14
`define MIE_INC_SKIP_CODE   6'h0f
`define MIE_STORE_W_CODE    7'h37
`define MIE_FF_MOVE_CODE    4'hc
`define MIE_BANK_LIT_CODE   8'h01
`define MIE_PTR_LOAD_CODE   10'h3b8
`define MIE_CALL_CODE       7'h76
`define MIE_GOTO_CODE       8'hef

// ****************************************************************
// Access bank split and protected destinations
// ****************************************************************
`define MIE_ACC_SPLIT       8'h80
`define MIE_ACC_LOW_BANK    4'h0
`define MIE_ACC_HIGH_BANK   4'hf
`define MIE_PC_LOW_ADDR     12'hff9
`define MIE_TOS_UPPER_ADDR  12'hfff
`define MIE_TOS_HIGH_ADDR   12'hffe
`define MIE_TOS_LOW_ADDR    12'hffd

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define MIE_PTR_COUNT       3
`define MIE_ZERO_BYTE       8'h00
`define MIE_ONE_BYTE        8'h01

`endif

// file: include/mie_pkg.sv
// Types shared by the move and increment execution block
`include "mie_consts.svh"

package mie_pkg;

    // ****************************************************************
    // Operation held for the current instruction cycle
    // ****************************************************************
    typedef enum logic [3:0]
    {
        OP_NOP,     // Idle, skipped or unknown word
        OP_MOVE_FILE, // move_file_op
        OP_INC_SKIP,  // increment_skip_zero_op
        OP_STORE_W,   // store_working_op
        OP_BANK_LIT,  // bank_literal_load_op
        OP_FF1,     // file_to_file_move_op, source cycle
        OP_FF2,     // file_to_file_move_op, destination cycle
        OP_LF1,     // pointer_literal_load_op, high part
        OP_LF2      // pointer_literal_load_op, low part
    } mie_op_e;

    // Which word the next decode phase expects
    typedef enum logic [1:0]
    {
        ST_NORM,
        ST_FF2,
        ST_LF2
    } mie_st_e;

    // ****************************************************************
    // Complete state of the executor
    // ****************************************************************
    typedef struct packed
    {
        logic [1:0]                         phase;
        mie_st_e                            st;
        mie_op_e                            op;
        logic                               skip;
        logic                               dbit;
        logic [11:0]                        addr;
        logic [7:0]                         lit;
        logic [3:0]                         khi;
        logic [1:0]                         sel;
        logic [7:0]                         data;
        logic [7:0]                         w;
        logic [7:0]                         bank;
        logic [`MIE_PTR_COUNT-1:0][3:0]     ptr_hi;
        logic [`MIE_PTR_COUNT-1:0][7:0]     ptr_lo;
        logic [7:0]                         wdata;
        logic                               we;
        logic                               zf;
        logic                               nf;
        logic                               bad_dest;
    } mie_state_s;

endpackage

// file: hdl/mie_bank_addr.sv
// Banked file address resolver for one-word file instructions
`timescale 1ns/1ps
`include "mie_consts.svh"

module mie_bank_addr
(
    input  wire logic [7:0]  file_i,   // Offset within the 256-byte bank
    input  wire logic        bank_a_i, // Zero picks the access bank
    input  wire logic [3:0]  bank_i,   // Bank selector low nibble
    output logic      [11:0] addr_o    // Full data memory address
);

    // ****************************************************************
    // Bank choice
    // ****************************************************************
    // Access bank mixes low bank 0 and high special-function bank
    always_comb
    begin
        if (!bank_a_i)
        begin
            if (file_i < `MIE_ACC_SPLIT)
                addr_o = {`MIE_ACC_LOW_BANK, file_i};
            else
                addr_o = {`MIE_ACC_HIGH_BANK, file_i};
        end
        else
        begin
            addr_o = {bank_i, file_i};
        end
    end

endmodule // mie_bank_addr

// file: verif/mie_exec_asserts.sv
// Port checks for the move and increment executor
`timescale 1ns/1ps

module mie_exec_asserts
#(
    parameter int NUM_PTR = 3 // Pointer count
)
(
    input wire logic                      clk_i,
    input wire logic                      rst_n_i,
    input wire logic [15:0]               instr_i,
    input wire logic                      instr_valid_i,
    input wire logic                      word_take_o,
    input wire logic [1:0]                phase_o,
    input wire logic [11:0]               mem_addr_o,
    input wire logic [7:0]                mem_rdata_i,
    input wire logic [7:0]                mem_wdata_o,
    input wire logic                      mem_we_o,
    input wire logic [7:0]                working_o,
    input wire logic [7:0]                bank_select_reg_o,
    input wire logic [NUM_PTR-1:0][11:0]  pointer_o,
    input wire logic                      zero_flag_o,
    input wire logic                      bad_dest_o
);
    // ********
    // Tracking of real instruction starts
    // ********
    logic [15:0] w;     // Word as the executor sees it
    logic        two;   // Word opens a two-word instruction
    logic        fst;   // Real instruction taken at this edge
    logic [1:0]  dc_q;  // 3: skip due, 1: non-start word due
    logic        inc_q; // Increment-skip to file under way
    logic [11:0] sa;    // Store address the rules expect
    assign w   = instr_valid_i ? instr_i : 16'h0000;
    assign two = w[15:12] == 4'hc || w[15:6] == 10'h3b8
               || w[15:9] == 7'h76 || w[15:8] == 8'hef;
    assign fst = word_take_o && dc_q == 2'd0;
    // Access bank splits at 0x80 between bank 0 and the top bank
    assign sa  = w[8] ? {bank_select_reg_o[3:0], w[7:0]}
                      : {{4{w[7]}}, w[7:0]};
    // Skips into W are unseen here, so only file results are tracked
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            {dc_q, inc_q} <= 3'h0;
        else if (word_take_o)
        begin
            dc_q  <= (dc_q != 2'd1 && two) ? 2'd1 : 2'd0;
            inc_q <= fst && w[15:9] == 7'h1f;
        end
        else if (phase_o == 2'd3 && inc_q && mem_we_o
                 && mem_wdata_o == 8'h00)
            dc_q <= 2'd3;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ff;
        fst && w[15:12] == 4'hc;
    endsequence
    sequence s_skip;
        fst && w[15:9] == 7'h1f ##3 mem_we_o && mem_wdata_o == 8'h00;
    endsequence
    property p_cycle;
        word_take_o |=> phase_o == 2'd1 ##1 phase_o == 2'd2
            ##1 phase_o == 2'd3 ##1 word_take_o;
    endproperty
    a_cycle: assert property (p_cycle)
        else $error("phase order broken");
    property p_move_file_op;
        fst && w[15:10] == 6'h14 && !w[9]
            |-> ##4 working_o == $past(mem_rdata_i, 3);
    endproperty
    a_move_file_op: assert property (p_move_file_op)
        else $error("move to W wrong");
    property p_store;
        fst && w[15:9] == 7'h37 |=> mem_addr_o == $past(sa)
            ##2 mem_we_o && mem_wdata_o == working_o;
    endproperty
    a_store: assert property (p_store)
        else $error("store address or data wrong");
    property p_bank;
        fst && w[15:8] == 8'h01 |-> (!mem_we_o)[*4]
            ##1 bank_select_reg_o == $past(w[7:0], 4)
            && zero_flag_o == $past(zero_flag_o, 4);
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank load wrong");
    property p_ptr;
        fst && w[15:4] == 12'hee2
            |-> ##4 pointer_o[2][11:8] == $past(w[3:0], 4)
            ##4 pointer_o[2][7:0] == $past(w[7:0], 4);
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("pointer load wrong");
    property p_ff;
        s_ff |-> ##7 (bad_dest_o ? !mem_we_o
            : mem_we_o && mem_wdata_o == $past(mem_rdata_i, 6));
    endproperty
    a_ff: assert property (p_ff)
        else $error("file move wrong");
    property p_prot;
        s_ff ##4 (word_take_o && w[11:0] inside
            {12'hff9, 12'hffd, 12'hffe, 12'hfff})
            |-> ##3 bad_dest_o && !mem_we_o;
    endproperty
    a_prot: assert property (p_prot)
        else $error("protected write done");
    property p_skip;
        s_skip |=> (!mem_we_o && $stable(bank_select_reg_o))[*5];
    endproperty
    a_skip: assert property (p_skip)
        else $error("skipped word acted");
endmodule // mie_exec_asserts

// file: verif/mie_mem_model.sv
// Data memory model facing the executor
`timescale 1ns/1ps

module mie_mem_model
(
    input  wire logic        clk_i,   // Core clock
    input  wire logic [11:0] addr_i,  // Data address
    input  wire logic [7:0]  wdata_i, // Write data
    input  wire logic        we_i,    // Write strobe
    output logic      [7:0]  rdata_o  // Read data
);
    // Whole 4 KB space; the bench preloads and peeks it
    logic [7:0] mem [4096];
    // Answers at once, executor samples at end of phase 1
    assign rdata_o = mem[addr_i];
    // Write lands at the edge closing phase 3
    always @(posedge clk_i)
    begin
        if (we_i)
            mem[addr_i] <= wdata_i;
    end
endmodule // mie_mem_model

// file: verif/move_increment_instr_exec_bench.sv
// Self-checking bench for the move and increment executor
`timescale 1ns/1ps

module move_increment_instr_exec_bench;
    logic             clk_i, rst_n_i;     // Clock, reset
    logic [15:0]      instr_i;            // Offered word
    logic             instr_valid_i;      // Word present
    logic             word_take_o, mem_we_o, bad_dest_o; // Strobes
    logic [1:0]       phase_o;            // Phase
    logic [11:0]      mem_addr_o;         // Data address
    logic [7:0]       mem_rdata_i, mem_wdata_o; // Data
    logic [7:0]       working_o, bank_select_reg_o; // W, bank
    logic [2:0][11:0] pointer_o;          // Pointers
    logic             zero_flag_o, neg_flag_o; // Flags
    int               bad_count, num_checks; // Tallies

    mie_exec #(.NUM_PTR(3)) i_mie_exec
    (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .word_take_o(word_take_o),
        .phase_o(phase_o), .mem_addr_o(mem_addr_o),
        .mem_rdata_i(mem_rdata_i), .mem_wdata_o(mem_wdata_o),
        .mem_we_o(mem_we_o), .working_o(working_o),
        .bank_select_reg_o(bank_select_reg_o), .pointer_o(pointer_o),
        .zero_flag_o(zero_flag_o), .neg_flag_o(neg_flag_o),
        .bad_dest_o(bad_dest_o)
    );
    mie_mem_model i_mie_mem_model
    (
        .clk_i(clk_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
        .we_i(mem_we_o), .rdata_o(mem_rdata_i)
    );

    task automatic print_verdict;
        $display("mismatches %0d, checks %0d", bad_count, num_checks);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] m(input int a);
        return i_mie_mem_model.mem[a];
    endfunction

    // Word set at the edge closing phase 3, stands through phase 0
    task automatic put(input logic [15:0] w, input logic v = 1'b1);
        int n;
        n = 0;
        @(posedge clk_i);
        while (phase_o !== 2'd3)
        begin
            n++;
            if (n > 8)
            begin
                bad_count++;
                print_verdict();
            end
            @(posedge clk_i);
        end
        instr_i       <= w;
        instr_valid_i <= v;
    endtask

    // Absent words must act as no-ops; this one would load the bank
    task automatic idle;
        put(16'h0109, 1'b0);
        put(16'h0109, 1'b0);
    endtask

    task automatic t_move;
        put(16'h0105);
        put(16'h515a);
        idle();
        chk(zero_flag_o, 12'h001);
        chk(working_o, 12'h000);
        put(16'h51d0);
        idle();
        chk(neg_flag_o, 12'h001);
        chk(working_o, 12'h08a);
        put(16'h5120);
        idle();
        chk(working_o, 12'h07a);
        chk(neg_flag_o, 12'h000);
        put(16'h535a);
        idle();
        chk(zero_flag_o, 12'h001);
        chk(working_o, 12'h07a);
        chk(bank_select_reg_o, 12'h005);
    endtask

    task automatic t_store;
        put(16'h6f10);
        put(16'h6e10);
        put(16'h6e90);
        idle();
        chk(m(12'h510), 12'h07a);
        chk(m(12'h010), 12'h07a);
        chk(m(12'hf90), 12'h07a);
    endtask

    // One plain data destination, then the protected PC low byte, then a pointer load
    task automatic t_ff;
        put(16'hc520);
        put(16'hf123);
        put(16'hc520);
        put(16'hfff9);
        idle();
        chk(m(12'h123), 12'h07a);
        chk(m(12'hff9), 12'h0a3);
        put(16'hee23);
        put(16'hf0ab);
        idle();
        chk(pointer_o[2], 12'h3ab);
    endtask

    // Skip over one word, then over a two-word load, then no skip
    task automatic t_skip;
        i_mie_mem_model.mem[12'h530] = 8'hff;
        i_mie_mem_model.mem[12'h531] = 8'hff;
        put(16'h3f30);
        put(16'h0109);
        put(16'h3f31);
        put(16'hee01);
        put(16'hf0cd);
        put(16'h3f32);
        put(16'h0107);
        idle();
        chk(m(12'h531), 12'h000);
        chk(m(12'h532), 12'h069);
        chk(pointer_o[0], 12'h000);
        chk(bank_select_reg_o, 12'h007);
        put(16'h3d40);
        idle();
        chk(working_o, 12'h01b);
        chk(m(12'h740), 12'h01a);
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial
    begin
        rst_n_i = 1'b0;
        instr_i = 16'h0000;
        instr_valid_i = 1'b0;
        bad_count = 0;
        num_checks = 0;
        for (int i = 0; i < 4096; i++)
            i_mie_mem_model.mem[i] = 8'(i) ^ 8'h5a;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_move();
        t_store();
        t_ff();
        t_skip();
        print_verdict();
    end
endmodule // move_increment_instr_exec_bench

bind mie_exec mie_exec_asserts #(.NUM_PTR(NUM_PTR)) i_mie_exec_asserts
(
    .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .word_take_o(word_take_o),
    .phase_o(phase_o), .mem_addr_o(mem_addr_o),
    .mem_rdata_i(mem_rdata_i), .mem_wdata_o(mem_wdata_o),
    .mem_we_o(mem_we_o), .working_o(working_o),
    .bank_select_reg_o(bank_select_reg_o), .pointer_o(pointer_o),
    .zero_flag_o(zero_flag_o), .bad_dest_o(bad_dest_o)
);
